// *** hw/frc_defines.svh ***
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH

// ==========================================================
// register map
`define FRC_CSR_ADDR      8'h00
`define FRC_CSR_RST       32'h0000_0000

// ==========================================================
// field positions inside the status/control word
`define FRC_RN_LSB        0
`define FRC_UE_BIT        2
`define FRC_OE_BIT        3
`define FRC_VE_BIT        4
`define FRC_UX_BIT        8
`define FRC_OX_BIT        9
`define FRC_XX_BIT        10
`define FRC_SIGNALING_NAN_INVALID_FLAG_BIT    11
`define FRC_INVALID_CONVERT_FLAG_BIT     12
`define FRC_FR_BIT        13
`define FRC_FI_BIT        14
`define FRC_CLS_LSB       16

// ==========================================================
// exponent limits (biased 11-bit, or signed 13-bit unbiased)
`define FRC_UFL_EXP       11'h381
`define FRC_OVF_EXP       11'h47E
`define FRC_EXP_MAX       11'h7FF
`define FRC_INT_EXP       11'h41E
`define FRC_BIAS          13'h03FF
`define FRC_DEN_EXP       13'h1C02
`define FRC_SGL_EMIN      13'h1F82
`define FRC_SGL_EMAX      13'h007F
`define FRC_EXP_ADJ       13'h00C0
`define FRC_INT_TOP       13'h003F

// ==========================================================
// fixed result patterns
`define FRC_POS_INF       64'h7FF0_0000_0000_0000
`define FRC_NEG_INF       64'hFFF0_0000_0000_0000
`define FRC_POS_MAXS      64'h47EF_FFFF_E000_0000
`define FRC_NEG_MAXS      64'hC7EF_FFFF_E000_0000
`define FRC_I64_MAX       64'h7FFF_FFFF_FFFF_FFFF
`define FRC_I64_MIN       64'h8000_0000_0000_0000
`define FRC_I32_MAX       64'h0000_0000_7FFF_FFFF
`define FRC_I32_MIN       64'h0000_0000_8000_0000

`endif

// *** hw/frc_pkg.sv ***
package frc_pkg;

  // ==========================================================
  // rounding modes, in field order: nearest, zero, +inf, -inf
  typedef enum logic [1:0] {RND_NEAR, RND_ZERO, RND_PINF, RND_MINF} frc_rnd_t;

  // operations issued by the pipeline
  typedef enum logic [2:0] {OP_RSP, OP_CTIW, OP_CTIWZ, OP_CTID, OP_CTIDZ} frc_op_t;

  // result class field values
  typedef enum logic [3:0] {
    CLS_UNDEF, CLS_PZERO, CLS_NZERO, CLS_PDEN, CLS_NDEN,
    CLS_PNORM, CLS_NNORM, CLS_PINF, CLS_NINF, CLS_QNAN
  } frc_class_t;

  // operation request from the pipeline
  typedef struct packed {
    frc_op_t     op;
    logic [63:0] src;
  } frc_req_t;

  // answer toward the register file
  typedef struct packed {
    logic        wr;
    logic [63:0] data;
  } frc_res_t;

  // status/control state
  typedef struct packed {
    frc_class_t cls;
    logic       fi;
    logic       fr;
    logic       invalid_convert_flag;
    logic       signaling_nan_invalid_flag;
    logic       xx;
    logic       ox;
    logic       ux;
    logic       ve;
    logic       oe;
    logic       ue;
    frc_rnd_t   rn;
  } frc_csr_t;

endpackage

// *** hw/frc_unit.sv ***
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "frc_defines.svh"

// Behaviour
// RL1 - nonzero source below exponent 897 takes underflow path chosen by trap enable
// RL2 - exponent 1151 to 2046 takes overflow path chosen by overflow trap enable
// RL3 - exponent 2047: zero fraction infinity, fraction msb set quiet, else signaling
// RL4 - untrapped underflow denormalizes to -126, flags lost bits, rounds, classifies
// RL5 - trapped underflow sets flag, normalizes, rounds, adds 192 to exponent
// RL6 - untrapped overflow: flag, inexact set, infinity or max single by mode/sign
// RL7 - in-range operands round; exponent above 127 enters overflow, trapped subtracts 192
// RL8 - zero and infinity copied with signed class; zero clears rounded/inexact
// RL9 - quiet NaN keeps upper 35 bits, low 29 zero, class quiet NaN
// RL10 - signaling NaN flags invalid; untrapped writes quieted value, class quiet NaN
// RL11 - single rounding: lsb bit 23, guard 24, round 25, sticky the rest
// RL12 - increment by mode: nearest, plus, minus infinity, truncate never
// RL13 - carry renormalizes and bumps exponent; rounded = increment, inexact = g|r|x
// RL14 - each rounding ORs fraction-inexact into sticky inexact flag
// RL15 - word and doubleword conversion, each with current mode or toward zero
// RL16 - conversion source exponent above 1054 is out of range directly
// RL17 - 65-bit significand shifted right 63 minus exponent; denormal uses -1022
// RL18 - integer rounding uses same increment with bit 64 as lsb
// RL19 - after negation results outside target signed range are out of range
// RL20 - word result in low half, doubleword full; class becomes undefined
// RL21 - infinity/out of range flags invalid convert, writes saturated integer
// RL22 - NaN flags invalid convert (plus signaling), writes most negative integer
// RL23 - trapped invalid leaves target unwritten but still updates flags
// RL24 - source bit 63 is sign, 62:52 exponent, 51:0 fraction
module frc_unit
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              op_valid,
  input  wire frc_pkg::frc_req_t req,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   res_valid,
  output frc_pkg::frc_res_t      res
);

  // ==========================================================
  // helpers

  // right shift collecting shifted-out bits into bit 0
  function automatic logic [127:0] frc_shr_st(input logic [127:0] v, input logic [12:0] amt);
    logic [127:0] r;
    r = '0;
    if (amt >= 13'h0080)
      r[0] = |v;
    else
    begin
      r = v >> amt;
      r[0] = r[0] | (|(v & ~({128{1'b1}} << amt)));
    end
    return r;
  endfunction

  // leading zero count of a 53-bit significand
  function automatic logic [5:0] frc_lzc(input logic [52:0] v);
    logic [5:0] n;
    n = 6'h35;
    for (int i = 0; i < 53; i++)
      if (v[i])
        n = 6'(52 - i);
    return n;
  endfunction

  // mode dependent increment decision
  function automatic logic frc_inc(input frc_pkg::frc_rnd_t m, input logic s,
                                   input logic lsb, input logic g, input logic r, input logic x);
    logic inc;
    inc = 1'b0;
    unique case (m)
      frc_pkg::RND_NEAR: inc = g & (lsb | r | x); // RL12
      frc_pkg::RND_ZERO: inc = 1'b0;
      frc_pkg::RND_PINF: inc = ~s & (g | r | x);
      frc_pkg::RND_MINF: inc = s & (g | r | x);
    endcase
    return inc;
  endfunction

  // assemble a double from sign, unbiased exponent and significand
  function automatic logic [63:0] frc_pack(input logic s, input logic [12:0] ex,
                                           input logic [52:0] fr);
    logic [12:0] be;
    be = ex + `FRC_BIAS;
    return {s, be[10:0], fr[51:0]};
  endfunction

  // untrapped overflow answer by mode and sign
  function automatic logic [63:0] frc_ovf_val(input frc_pkg::frc_rnd_t m, input logic s);
    logic big;
    big = (m == frc_pkg::RND_NEAR) || (m == frc_pkg::RND_PINF && !s) ||
          (m == frc_pkg::RND_MINF && s);
    if (big)
      return s ? `FRC_NEG_INF : `FRC_POS_INF;
    return s ? `FRC_NEG_MAXS : `FRC_POS_MAXS;
  endfunction

  // class of a double built by this block
  function automatic frc_pkg::frc_class_t frc_cls(input logic [63:0] d);
    if (d[62:52] == `FRC_EXP_MAX)
      return d[63] ? frc_pkg::CLS_NINF : frc_pkg::CLS_PINF;
    if (d[62:52] == 11'h000)
      return d[63] ? frc_pkg::CLS_NDEN : frc_pkg::CLS_PDEN;
    return d[63] ? frc_pkg::CLS_NNORM : frc_pkg::CLS_PNORM;
  endfunction

  // ==========================================================
  // state
  frc_pkg::frc_csr_t csr_r,     csr_nxt;
  logic [31:0]       rdata_r,   rdata_nxt;
  logic              rvalid_r,  rvalid_nxt;
  frc_pkg::frc_res_t res_r,     res_nxt;

  // ==========================================================
  // operand decode
  logic               src_s;
  logic [10:0]        src_e;
  logic [51:0]        src_f;
  logic               is_zero, is_inf, is_nan, is_snan;
  logic               is_word, is_rsp;
  logic [12:0]        exp0;
  logic [52:0]        fr0;
  frc_pkg::frc_rnd_t  rmode;

  // bit 63 is the architectural bit 0
  always_comb
  begin
    src_s   = req.src[63]; // RL24
    src_e   = req.src[62:52];
    src_f   = req.src[51:0];
    is_zero = (src_e == 11'h000) && (src_f == 52'h0);
    is_inf  = (src_e == `FRC_EXP_MAX) && (src_f == 52'h0); // RL3
    is_nan  = (src_e == `FRC_EXP_MAX) && (src_f != 52'h0);
    is_snan = is_nan && !src_f[51];
    is_rsp  = (req.op == frc_pkg::OP_RSP);
    is_word = (req.op == frc_pkg::OP_CTIW) || (req.op == frc_pkg::OP_CTIWZ); // RL15
    rmode   = (req.op == frc_pkg::OP_CTIWZ || req.op == frc_pkg::OP_CTIDZ) ?
              frc_pkg::RND_ZERO : csr_r.rn;
    exp0    = (src_e == 11'h000) ? `FRC_DEN_EXP : 13'({2'b00, src_e}) - `FRC_BIAS; // RL17
    fr0     = {src_e != 11'h000, src_f};
  end

  // ==========================================================
  // round to single datapath
  logic               s_ufl, s_ovf;
  logic [127:0]       s_sh;
  logic [52:0]        s_fr1, s_fr2, s_frn;
  logic [12:0]        s_exp1, s_exp2;
  logic               s_g, s_r, s_x, s_ux, s_inc, s_fi;
  logic [24:0]        s_sum;
  logic [5:0]         s_lz;

  // prepare, round, renormalize; trapped underflow pre-normalizes instead
  always_comb
  begin
    s_ufl  = (src_e < `FRC_UFL_EXP) && !is_zero; // RL1
    s_ovf  = (src_e > `FRC_OVF_EXP) && (src_e < `FRC_EXP_MAX); // RL2
    s_sh   = frc_shr_st({72'h0, fr0, 3'b000}, `FRC_SGL_EMIN - exp0);
    s_lz   = frc_lzc(fr0);
    s_fr1  = fr0;
    s_exp1 = exp0;
    s_g    = 1'b0;
    s_r    = 1'b0;
    s_x    = 1'b0;
    if (s_ufl && !csr_r.ue)
    begin
      s_fr1  = s_sh[55:3]; // RL4
      s_g    = s_sh[2];
      s_r    = s_sh[1];
      s_x    = s_sh[0];
      s_exp1 = `FRC_SGL_EMIN;
    end
    else if (s_ufl)
    begin
      s_fr1  = fr0 << s_lz; // RL5
      s_exp1 = exp0 - 13'(s_lz);
    end
    s_ux   = (|s_fr1[28:0]) | s_g | s_r | s_x;
    // guard/round/sticky below the 24-bit single significand
    s_inc  = frc_inc(csr_r.rn, src_s, s_fr1[29], s_fr1[28], s_fr1[27],
                     (|s_fr1[26:0]) | s_g | s_r | s_x); // RL11
    s_fi   = s_fr1[28] | s_fr1[27] | (|s_fr1[26:0]) | s_g | s_r | s_x;
    s_sum  = {1'b0, s_fr1[52:29]} + 25'(s_inc);
    s_exp2 = s_exp1 + 13'(s_sum[24]);
    // carry shifts a leading one back in, low 29 bits cleared
    s_fr2  = s_sum[24] ? {1'b1, s_sum[23:1], 29'h0} : {s_sum[23:0], 29'h0}; // RL13
    s_lz   = frc_lzc(s_fr2);
    s_frn  = s_fr2 << s_lz;
  end

  // ==========================================================
  // convert to integer datapath
  logic [127:0]       i_sh;
  logic [64:0]        i_fr, i_sum, i_val;
  logic               i_inc, i_fi, i_big, i_oor;

  // align, round, negate, range check
  always_comb
  begin
    i_sh  = frc_shr_st({60'h0, 1'b0, fr0, 11'h000, 3'b000}, `FRC_INT_TOP - exp0); // RL17
    i_fr  = i_sh[67:3];
    i_inc = frc_inc(rmode, src_s, i_fr[0], i_sh[2], i_sh[1], i_sh[0]); // RL18
    i_fi  = i_sh[2] | i_sh[1] | i_sh[0];
    i_sum = i_fr + 65'(i_inc);
    i_val = src_s ? (~i_sum + 65'h1) : i_sum;
    i_big = src_e > `FRC_INT_EXP; // RL16
    // out of range unless the top bits are pure sign extension
    i_oor = is_word ? !((&i_val[64:31]) || !(|i_val[64:31]))
                    : !((&i_val[64:63]) || !(|i_val[64:63])); // RL19
  end

  // ==========================================================
  // result selection and flag effects
  logic [63:0]         r_data, i_sat;
  logic                r_wr, f_updfr, f_fr, f_fi, f_updcls;
  logic                f_ux, f_ox, f_xx, f_vxs, f_vxc;
  frc_pkg::frc_class_t f_cls;

  always_comb
  begin
    r_data   = req.src;
    r_wr     = 1'b1;
    f_updfr  = 1'b1;
    f_fr     = 1'b0;
    f_fi     = 1'b0;
    f_updcls = 1'b1;
    f_cls    = frc_pkg::CLS_UNDEF;
    f_ux     = 1'b0;
    f_ox     = 1'b0;
    f_xx     = 1'b0;
    f_vxs    = 1'b0;
    f_vxc    = 1'b0;
    if (is_word)
      i_sat = src_s ? `FRC_I32_MIN : `FRC_I32_MAX;
    else
      i_sat = src_s ? `FRC_I64_MIN : `FRC_I64_MAX;
    if (is_rsp)
    begin
      if (s_ufl)
      begin
        f_ux   = csr_r.ue ? 1'b1 : s_ux; // RL4 RL5
        f_fr   = s_inc;
        f_fi   = s_fi;
        f_xx   = s_fi; // RL14
        if (csr_r.ue)
          r_data = frc_pack(src_s, s_exp2 + `FRC_EXP_ADJ, s_fr2); // RL5
        else if (s_fr2 == 53'h0)
          r_data = {src_s, 63'h0};
        else
          r_data = frc_pack(src_s, s_exp2 - 13'(s_lz), s_frn);
        // denormal result still carries the denormal class
        f_cls  = (!csr_r.ue && !s_fr2[52] && s_fr2 != 53'h0) ?
                 (src_s ? frc_pkg::CLS_NDEN : frc_pkg::CLS_PDEN) : frc_cls(r_data);
        if (s_fr2 == 53'h0)
          f_cls = src_s ? frc_pkg::CLS_NZERO : frc_pkg::CLS_PZERO;
      end
      else if (s_ovf || (!is_zero && !is_nan && !is_inf))
      begin
        f_fr = s_inc;
        f_fi = s_fi;
        f_xx = s_fi; // RL14
        r_data = frc_pack(src_s, s_exp2, s_fr2); // RL7
        if (s_ovf || $signed(s_exp2) > $signed(`FRC_SGL_EMAX))
        begin
          f_ox = 1'b1;
          if (csr_r.oe)
            r_data = frc_pack(src_s, s_exp2 - `FRC_EXP_ADJ, s_fr2); // RL7
          else
          begin
            r_data = frc_ovf_val(csr_r.rn, src_s); // RL6
            f_fr   = 1'b0;
            f_fi   = 1'b1;
            f_xx   = 1'b1;
          end
        end
        f_cls = frc_cls(r_data);
      end
      else if (is_zero)
        f_cls = src_s ? frc_pkg::CLS_NZERO : frc_pkg::CLS_PZERO; // RL8
      else if (is_inf)
      begin
        f_updfr = 1'b0;
        f_cls   = src_s ? frc_pkg::CLS_NINF : frc_pkg::CLS_PINF; // RL8
      end
      else if (!is_snan)
      begin
        r_data = {req.src[63:29], 29'h0}; // RL9
        f_cls  = frc_pkg::CLS_QNAN;
      end
      else
      begin
        f_vxs    = 1'b1; // RL10
        r_wr     = !csr_r.ve; // RL23
        f_updcls = !csr_r.ve;
        r_data   = {req.src[63:52], 1'b1, req.src[50:29], 29'h0};
        f_cls    = frc_pkg::CLS_QNAN;
      end
    end
    else
    begin
      if (is_nan)
      begin
        f_vxc  = 1'b1; // RL22
        f_vxs  = is_snan;
        r_data = is_word ? `FRC_I32_MIN : `FRC_I64_MIN;
        r_wr   = !csr_r.ve; // RL23
      end
      else if (is_inf || i_big || i_oor)
      begin
        f_vxc  = 1'b1; // RL21
        r_data = i_sat;
        r_wr   = !csr_r.ve; // RL23
      end
      else
      begin
        f_fr   = i_inc; // RL18
        f_fi   = i_fi;
        f_xx   = i_fi; // RL14
        // word result in the low half, upper half left zero
        r_data = is_word ? {32'h0, i_val[31:0]} : i_val[63:0]; // RL20
      end
      f_updcls = r_wr;
    end
  end

  // ==========================================================
  // register port and state update; hardware sets win over software
  always_comb
  begin
    csr_nxt    = csr_r;
    rdata_nxt  = 32'h0000_0000;
    rvalid_nxt = op_valid;
    res_nxt    = res_r;
    if (reg_rd && reg_addr == `FRC_CSR_ADDR)
    begin
      rdata_nxt[`FRC_RN_LSB+:2]  = csr_r.rn;
      rdata_nxt[`FRC_UE_BIT]     = csr_r.ue;
      rdata_nxt[`FRC_OE_BIT]     = csr_r.oe;
      rdata_nxt[`FRC_VE_BIT]     = csr_r.ve;
      rdata_nxt[`FRC_UX_BIT]     = csr_r.ux;
      rdata_nxt[`FRC_OX_BIT]     = csr_r.ox;
      rdata_nxt[`FRC_XX_BIT]     = csr_r.xx;
      rdata_nxt[`FRC_SIGNALING_NAN_INVALID_FLAG_BIT] = csr_r.signaling_nan_invalid_flag;
      rdata_nxt[`FRC_INVALID_CONVERT_FLAG_BIT]  = csr_r.invalid_convert_flag;
      rdata_nxt[`FRC_FR_BIT]     = csr_r.fr;
      rdata_nxt[`FRC_FI_BIT]     = csr_r.fi;
      rdata_nxt[`FRC_CLS_LSB+:4] = csr_r.cls;
    end
    if (reg_wr && reg_addr == `FRC_CSR_ADDR)
    begin
      csr_nxt.rn     = frc_pkg::frc_rnd_t'(reg_wdata[`FRC_RN_LSB+:2]);
      csr_nxt.ue     = reg_wdata[`FRC_UE_BIT];
      csr_nxt.oe     = reg_wdata[`FRC_OE_BIT];
      csr_nxt.ve     = reg_wdata[`FRC_VE_BIT];
      csr_nxt.ux     = reg_wdata[`FRC_UX_BIT];
      csr_nxt.ox     = reg_wdata[`FRC_OX_BIT];
      csr_nxt.xx     = reg_wdata[`FRC_XX_BIT];
      csr_nxt.signaling_nan_invalid_flag = reg_wdata[`FRC_SIGNALING_NAN_INVALID_FLAG_BIT];
      csr_nxt.invalid_convert_flag  = reg_wdata[`FRC_INVALID_CONVERT_FLAG_BIT];
      csr_nxt.fr     = reg_wdata[`FRC_FR_BIT];
      csr_nxt.fi     = reg_wdata[`FRC_FI_BIT];
      csr_nxt.cls    = frc_pkg::frc_class_t'(reg_wdata[`FRC_CLS_LSB+:4]);
    end
    if (op_valid)
    begin
      csr_nxt.ux     = csr_nxt.ux | f_ux;
      csr_nxt.ox     = csr_nxt.ox | f_ox;
      csr_nxt.xx     = csr_nxt.xx | f_xx; // RL14
      csr_nxt.signaling_nan_invalid_flag = csr_nxt.signaling_nan_invalid_flag | f_vxs;
      csr_nxt.invalid_convert_flag  = csr_nxt.invalid_convert_flag | f_vxc;
      if (f_updfr)
      begin
        csr_nxt.fr = f_fr;
        csr_nxt.fi = f_fi;
      end
      if (f_updcls)
        csr_nxt.cls = f_cls;
      res_nxt.wr   = r_wr;
      res_nxt.data = r_data;
    end
    else
      res_nxt.wr = 1'b0;
  end

  // plain register stage; answers one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // status word is narrower than the bus word: cut to the struct width first
      csr_r    <= frc_pkg::frc_csr_t'(16'(`FRC_CSR_RST));
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      res_r    <= '0;
    end
    else
    begin
      csr_r    <= csr_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      res_r    <= res_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign res_valid = rvalid_r;
  assign res       = res_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic rq_rsp, rq_cti;
  assign rq_rsp = op_valid && is_rsp;
  assign rq_cti = op_valid && !is_rsp;

  ufl_flag_a: assert property (rq_rsp && s_ufl && csr_r.ue |=> csr_r.ux && res.wr) // RL5
    else $error("trapped underflow did not set flag");
  ovf_flag_a: assert property (rq_rsp && s_ovf |=> csr_r.ox) // RL2
    else $error("overflow source did not set flag");
  qnan_class_a: assert property (rq_rsp && is_nan && !is_snan
                                 |=> csr_r.cls == frc_pkg::CLS_QNAN && res.data[28:0] == 29'h0)
    else $error("quiet NaN not passed correctly"); // RL9
  ovf_inexact_a: assert property (rq_rsp && s_ovf && !csr_r.oe |=> csr_r.fi && csr_r.xx) // RL6
    else $error("untrapped overflow not inexact");
  zero_copy_a: assert property (rq_rsp && is_zero
                                |=> res.data == $past(req.src) && !csr_r.fr && !csr_r.fi)
    else $error("zero not copied"); // RL8
  int_big_a: assert property (rq_cti && i_big && !is_nan && !csr_r.ve |=> csr_r.invalid_convert_flag
                              && res.wr && ($past(is_word)
                              ? res.data[30:0] == {31{!res.data[31]}}
                              : res.data[62:0] == {63{!res.data[63]}}))
    else $error("large operand not saturated"); // RL16
  nan_int_a: assert property (rq_cti && is_nan && !is_word && !csr_r.ve
                              |=> res.data == `FRC_I64_MIN && csr_r.invalid_convert_flag)
    else $error("NaN conversion wrong"); // RL22
  trap_hold_a: assert property (op_valid && csr_r.ve && (is_snan || (!is_rsp && (is_nan
                                || is_inf || i_big))) |=> res_valid && !res.wr)
    else $error("target written under invalid trap"); // RL23
  snan_flag_a: assert property (op_valid && is_snan |=> csr_r.signaling_nan_invalid_flag ##1 1) // RL10
    else $error("signaling NaN flag missing");

  rsp_norm_c:  cover property (rq_rsp && !s_ufl && !s_ovf && !is_zero && !is_nan ##1 res.wr);
  rsp_ufl_c:   cover property (rq_rsp && s_ufl && !csr_r.ue ##1 csr_r.ux);
  cti_round_c: cover property (rq_cti && i_inc && !i_oor ##1 csr_r.fr);

endmodule

// *** sim/frc_pipe_model.sv ***
`timescale 1ns/100ps

// ==========================================================
// pipeline side: issues one operation per call, strobe one cycle
module frc_pipe_model
(
  input  wire logic              clk_sys,
  output logic                   op_valid,
  output frc_pkg::frc_req_t      req
);

  // idle until the first request
  initial
  begin
    op_valid = 1'b0;
    req      = '0;
  end

  // released source goes inverted so a stale operand never looks live
  task automatic issue(input frc_pkg::frc_op_t op, input logic [63:0] src);
    op_valid <= 1'b1;
    req.op   <= op;
    req.src  <= src;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    req.src  <= ~src;
  endtask

endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`include "frc_defines.svh"

`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("Error %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end

module testbench;

  // ==========================================================
  // operation and control shorthands
  localparam frc_pkg::frc_op_t RS  = frc_pkg::OP_RSP;
  localparam frc_pkg::frc_op_t CW  = frc_pkg::OP_CTIW;
  localparam frc_pkg::frc_op_t CWZ = frc_pkg::OP_CTIWZ;
  localparam frc_pkg::frc_op_t CD  = frc_pkg::OP_CTID;
  localparam frc_pkg::frc_op_t CDZ = frc_pkg::OP_CTIDZ;
  localparam logic [31:0]      N   = 32'h0;
  localparam logic [31:0]      ZR  = 32'h1;
  localparam logic [31:0]      P   = 32'h2;
  localparam logic [31:0]      M   = 32'h3;
  localparam logic [31:0]      UE  = 32'h1 << `FRC_UE_BIT;
  localparam logic [31:0]      OE  = 32'h1 << `FRC_OE_BIT;
  localparam logic [31:0]      VE  = 32'h1 << `FRC_VE_BIT;

  logic              clk_sys;
  logic              rst_n;
  logic              op_valid;
  frc_pkg::frc_req_t req;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              res_valid;
  frc_pkg::frc_res_t res;
  int                n_errors;
  int                n_compared;
  int                cycles;

  frc_unit u_dut
  (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .op_valid  (op_valid),
    .req       (req),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .res_valid (res_valid),
    .res       (res)
  );

  frc_pipe_model u_pipe
  (
    .clk_sys  (clk_sys),
    .op_valid (op_valid),
    .req      (req)
  );

  // ==========================================================
  // clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // a full run needs some hundred cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // bus and operation helpers
  task automatic csr_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic csr_rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // control word c is written first, so sticky flags start clear
  task automatic rop(input frc_pkg::frc_op_t o, input logic [63:0] s, input logic [31:0] c,
                     input logic [63:0] d, input logic w, input logic [31:0] e);
    csr_wr(8'h00, c);
    u_pipe.issue(o, s);
    #1;
    `CHK(res_valid, 1'b1)
    `CHK(res.wr, w)
    if (w)
      `CHK(res.data, d)
    csr_rd(8'h00, c | e);
    `CHK(res_valid, 1'b0)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    csr_rd(8'h00, 32'h0);
    csr_wr(8'h04, 32'hFFFFFFFF);
    csr_rd(8'h04, 32'h0);
    csr_rd(8'h00, 32'h0);
  endtask

  task automatic t_round();
    rop(RS, 64'h3FF0000010000000, N, 64'h3FF0000000000000, 1'b1, 20'h54400);
    rop(RS, 64'h3FF0000030000000, N, 64'h3FF0000040000000, 1'b1, 20'h56400);
    rop(RS, 64'h3FF0000010000000, P, 64'h3FF0000020000000, 1'b1, 20'h56400);
    rop(RS, 64'hBFF0000010000000, M, 64'hBFF0000020000000, 1'b1, 20'h66400);
    rop(RS, 64'h3FF0000000000001, ZR, 64'h3FF0000000000000, 1'b1, 20'h54400);
    rop(RS, 64'h3FFFFFFFF0000000, N, 64'h4000000000000000, 1'b1, 20'h56400);
  endtask

  task automatic t_ovf();
    rop(RS, 64'h47F0000000000000, N, 64'h7FF0000000000000, 1'b1, 20'h74600);
    rop(RS, 64'h47F0000000000000, ZR, 64'h47EFFFFFE0000000, 1'b1, 20'h54600);
    rop(RS, 64'hC7F0000000000000, P, 64'hC7EFFFFFE0000000, 1'b1, 20'h64600);
    rop(RS, 64'h47F0000000000000, OE, 64'h3BF0000000000000, 1'b1, 20'h50200);
    rop(RS, 64'h47EFFFFFF0000000, N, 64'h7FF0000000000000, 1'b1, 20'h74600);
    rop(RS, 64'h47EFFFFFF0000000, OE, 64'h3BF0000000000000, 1'b1, 20'h56600);
  endtask

  task automatic t_ufl();
    rop(RS, 64'h3800000000000000, UE, 64'h4400000000000000, 1'b1, 20'h50100);
    rop(RS, 64'h36A0000000000001, N, 64'h36A0000000000000, 1'b1, 20'h34500);
    rop(RS, 64'h3600000000000000, N, 64'h0, 1'b1, 20'h14500);
  endtask

  task automatic t_special();
    rop(RS, 64'h8000000000000000, N, 64'h8000000000000000, 1'b1, 20'h20000);
    rop(RS, 64'hFFF0000000000000, N, 64'hFFF0000000000000, 1'b1, 20'h80000);
    rop(RS, 64'h7FF80000F2345678, N, 64'h7FF80000E0000000, 1'b1, 20'h90000);
    rop(RS, 64'h7FF00000F0000001, N, 64'h7FF80000E0000000, 1'b1, 20'h90800);
    rop(RS, 64'h7FF00000F0000001, VE, 64'h0, 1'b0, 20'h00800);
  endtask

  task automatic t_cvt();
    rop(CW, 64'h4004000000000000, N, 64'h2, 1'b1, 20'h04400);
    rop(CWZ, 64'hC004000000000000, P, 64'h00000000FFFFFFFE, 1'b1, 20'h04400);
    rop(CD, 64'h400C000000000000, N, 64'h4, 1'b1, 20'h06400);
    rop(CDZ, 64'h400C000000000000, M, 64'h3, 1'b1, 20'h04400);
    rop(CD, 64'h0000000000000001, P, 64'h1, 1'b1, 20'h06400);
    rop(CW, 64'h41E0000000000000, N, 64'h000000007FFFFFFF, 1'b1, 20'h01000);
    rop(CW, 64'hC1E0000000000000, N, 64'h0000000080000000, 1'b1, 20'h00000);
    rop(CD, 64'h41F0000000000000, N, 64'h7FFFFFFFFFFFFFFF, 1'b1, 20'h01000);
    rop(CD, 64'hFFF0000000000000, N, 64'h8000000000000000, 1'b1, 20'h01000);
    rop(CW, 64'h7FF8000000000000, N, 64'h0000000080000000, 1'b1, 20'h01000);
    rop(CD, 64'h7FF0000000000001, N, 64'h8000000000000000, 1'b1, 20'h01800);
    rop(CD, 64'h7FF0000000000001, VE, 64'h0, 1'b0, 20'h01800);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    n_errors   = 0;
    n_compared = 0;
    cycles     = 0;
    rst_n      = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_round();
    t_ovf();
    t_ufl();
    t_special();
    t_cvt();
    tally_and_finish();
  end

endmodule
